// ### rtl/iex_pkg.sv
`default_nettype none
package iex_pkg;
  // Each stack push moves the pointer down by one long word
  localparam logic [31:0] IEX_STACK_STEP = 32'h0000_0004;
  // Vector entries are long words
  localparam int unsigned IEX_VEC_SHIFT = 2;
  localparam logic [1:0] IEX_ALIGN_OK = 2'h0;

  typedef enum logic [2:0] {
    IEX_K_NONE = 3'b000,
    IEX_K_IRQ  = 3'b001,
    IEX_K_TRAP = 3'b010,
    IEX_K_SLOT = 3'b011,
    IEX_K_GEN  = 3'b100,
    IEX_K_ADE  = 3'b101
  } iex_kind_t;

  typedef enum logic [1:0] {
    IEX_IDLE      = 2'b00,
    IEX_PUSH_SR   = 2'b01,
    IEX_PUSH_PC   = 2'b10,
    IEX_FETCH_VEC = 2'b11
  } iex_state_t;

  // Pre-decoded instruction from the decode stage
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic [31:0] target;
    logic undefined;
    logic delayed_br;
    logic rewrites_pc;
    logic trap;
    logic [7:0] trap_vec;
    logic int_disable;
  } iex_dec_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } iex_bus_t;

  typedef struct packed {
    logic take;
    iex_kind_t kind;
    logic [7:0] vec;
    logic [31:0] push_pc;
  } iex_pick_t;

  typedef struct packed {
    logic in_slot;
    logic after_dis;
    logic [31:0] target;
    logic ade_pend;
  } iex_gate_st_t;

  typedef struct packed {
    iex_state_t st;
    iex_kind_t kind;
    logic [7:0] vec;
    logic [31:0] sp;
    logic [31:0] push_pc;
    logic ade_after;
    iex_bus_t bus;
    logic [31:0] pc;
    logic pc_load;
    logic sp_we;
    logic busy;
    logic go;
    logic irq_ack;
  } iex_core_t;

  localparam iex_pick_t IEX_PICK_NONE = '0;
  localparam iex_gate_st_t IEX_GATE_RST = '0;
  localparam iex_core_t IEX_CORE_RST = '0;
endpackage
`default_nettype wire

// ### rtl/iex_pick.sv
`timescale 1ns/100ps
`default_nettype none
module iex_pick import iex_pkg::*; #(
  parameter logic [7:0] VEC_SLOT = 8'h11,
  parameter logic [7:0] VEC_GEN = 8'h10,
  parameter logic [7:0] VEC_ADE = 8'h12
) (
  // Decoded instruction and acceptance context
  input wire iex_dec_t dec_i,
  input wire logic in_slot_i,
  input wire logic after_dis_i,
  input wire logic [31:0] slot_target_i,
  // Waiting requests
  input wire logic ade_pend_i,
  input wire logic irq_req_i,
  input wire logic [7:0] irq_vec_i,
  // Chosen exception
  output iex_pick_t pick_o
);
  logic ade_ok;
  logic irq_ok;
  logic slot_bad;

  always_comb begin
    pick_o = IEX_PICK_NONE;
    ade_ok = !in_slot_i;
    irq_ok = !in_slot_i && !after_dis_i;
    slot_bad = in_slot_i && (dec_i.undefined || dec_i.rewrites_pc || dec_i.trap);
    if (dec_i.valid) begin
      pick_o.take = 1'b1;
      // Held-off events win first at the first decode that may take them
      if (ade_pend_i && ade_ok) begin
        pick_o.kind = IEX_K_ADE;
        pick_o.vec = VEC_ADE;
        pick_o.push_pc = dec_i.pc;
      end else if (irq_req_i && irq_ok) begin
        pick_o.kind = IEX_K_IRQ;
        pick_o.vec = irq_vec_i;
        pick_o.push_pc = dec_i.pc;
      end else if (slot_bad) begin
        pick_o.kind = IEX_K_SLOT;
        pick_o.vec = VEC_SLOT;
        pick_o.push_pc = slot_target_i;
      end else if (dec_i.undefined) begin
        pick_o.kind = IEX_K_GEN;
        pick_o.vec = VEC_GEN;
        pick_o.push_pc = dec_i.pc;
      end else if (dec_i.trap) begin
        pick_o.kind = IEX_K_TRAP;
        pick_o.vec = dec_i.trap_vec;
        pick_o.push_pc = dec_i.next_pc;
      end else begin
        pick_o.take = 1'b0;
      end
    end
  end
endmodule // iex_pick
`default_nettype wire

// ### rtl/iex_gate.sv
`timescale 1ns/100ps
`default_nettype none
module iex_gate import iex_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Decode stage
  input wire iex_dec_t dec_i,
  input wire logic exec_i,
  // Address error requests
  input wire logic ade_req_i,
  input wire logic ade_take_i,
  // Acceptance context
  output logic in_slot_o,
  output logic after_dis_o,
  output logic [31:0] slot_target_o,
  output logic ade_pend_o
);
  iex_gate_st_t r;
  iex_gate_st_t n;

  always_comb begin
    n = r;
    if (dec_i.valid) begin
      // A taken exception cancels the instruction, so no slot follows
      n.in_slot = exec_i && dec_i.delayed_br;
      n.after_dis = exec_i && dec_i.int_disable;
      if (exec_i && dec_i.delayed_br) begin
        n.target = dec_i.target;
      end
    end
    // New request wins over the clear of the same cycle
    n.ade_pend = ade_req_i || (r.ade_pend && !ade_take_i);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= IEX_GATE_RST;
    end else begin
      r <= n;
    end
  end

  assign in_slot_o = r.in_slot;
  assign after_dis_o = r.after_dis;
  assign slot_target_o = r.target;
  assign ade_pend_o = r.ade_pend;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_ADE_KEPT: assert property (ade_req_i |=> ade_pend_o)
    else $error("address error request lost");
  AST_SLOT_MARK: assert property ((exec_i && dec_i.delayed_br) |=>
    in_slot_o && slot_target_o == $past(dec_i.target))
    else $error("delay slot not marked");
endmodule // iex_gate
`default_nettype wire

// ### rtl/iex_unit.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Trap pushes status word, then program counter
// - Trap saves address after trap instruction
// - Trap vector from instruction, non-delayed jump
// - Undefined opcode in delay slot: slot exception
// - PC-rewriting opcode in delay slot: slot exception
// - Slot exception saves preceding branch target
// - Slot exception uses own vector, non-delayed
// - Undefined opcode elsewhere: general illegal exception
// - General illegal saves its own address
// - No address error or interrupt in slot
// - After control load/store: interrupts held, errors not
// - Held exception taken at next allowed decode
// - Misaligned stack pointer during stacking: address error
// - Misaligned vector base on vector read: error
// - Stacking error: finish, then address error processing
// - Errors while stacking address error are ignored
// - Each push lowers stack pointer by four
// - Faulting stack write still goes on bus
module iex_unit import iex_pkg::*; #(
  parameter logic [7:0] VEC_SLOT = 8'h11,
  parameter logic [7:0] VEC_GEN = 8'h10,
  parameter logic [7:0] VEC_ADE = 8'h12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Decode stage
  input wire iex_dec_t dec_i,
  output logic dec_go_o,
  output logic busy_o,
  // CPU registers
  input wire logic [31:0] status_word_i,
  input wire logic [31:0] stack_pointer_i,
  input wire logic [31:0] vector_table_base_i,
  output logic [31:0] sp_o,
  output logic sp_we_o,
  output logic [31:0] pc_o,
  output logic pc_load_o,
  // Address errors and interrupts
  input wire logic ade_req_i,
  input wire logic irq_req_i,
  input wire logic [7:0] irq_vec_i,
  output logic irq_ack_o,
  // System bus
  output iex_bus_t bus_o,
  input wire logic bus_ack_i,
  input wire logic [31:0] bus_rdata_i
);
  iex_core_t r;
  iex_core_t n;
  iex_pick_t pk;
  logic in_slot;
  logic after_dis;
  logic [31:0] slot_target;
  logic ade_pend;
  logic decide;
  logic exec;
  logic ade_take;
  logic [31:0] vec_addr;

  // Decodes only count while the sequencer is idle
  assign decide = dec_i.valid && (r.st == IEX_IDLE);
  assign exec = decide && !pk.take;
  assign ade_take = decide && pk.take && (pk.kind == IEX_K_ADE);
  assign vec_addr = vector_table_base_i + (32'(r.vec) << IEX_VEC_SHIFT);

  iex_gate u_gate (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .dec_i(dec_i),
    .exec_i(exec),
    .ade_req_i(ade_req_i),
    .ade_take_i(ade_take),
    .in_slot_o(in_slot),
    .after_dis_o(after_dis),
    .slot_target_o(slot_target),
    .ade_pend_o(ade_pend)
  );

  iex_pick #(
    .VEC_SLOT(VEC_SLOT),
    .VEC_GEN(VEC_GEN),
    .VEC_ADE(VEC_ADE)
  ) u_pick (
    .dec_i(dec_i),
    .in_slot_i(in_slot),
    .after_dis_i(after_dis),
    .slot_target_i(slot_target),
    .ade_pend_i(ade_pend),
    .irq_req_i(irq_req_i),
    .irq_vec_i(irq_vec_i),
    .pick_o(pk)
  );

  always_comb begin
    n = r;
    n.pc_load = 1'b0;
    n.sp_we = 1'b0;
    n.go = 1'b0;
    n.irq_ack = 1'b0;
    unique case (r.st)
      IEX_IDLE: begin
        if (dec_i.valid) begin
          if (pk.take) begin
            n.kind = pk.kind;
            n.vec = pk.vec;
            n.push_pc = pk.push_pc;
            n.busy = 1'b1;
            n.irq_ack = (pk.kind == IEX_K_IRQ);
            // Status word goes first, one long word below the pointer
            n.sp = stack_pointer_i - IEX_STACK_STEP;
            n.sp_we = 1'b1;
            n.bus.req = 1'b1;
            n.bus.write = 1'b1;
            n.bus.addr = stack_pointer_i - IEX_STACK_STEP;
            n.bus.wdata = status_word_i;
            n.ade_after = (stack_pointer_i[1:0] != IEX_ALIGN_OK) &&
                          (pk.kind != IEX_K_ADE);
            n.st = IEX_PUSH_SR;
          end else begin
            n.go = 1'b1;
          end
        end
      end
      IEX_PUSH_SR: begin
        if (bus_ack_i) begin
          // Misaligned pointer is still stepped and still driven out
          n.sp = r.sp - IEX_STACK_STEP;
          n.sp_we = 1'b1;
          n.bus.addr = r.sp - IEX_STACK_STEP;
          n.bus.wdata = r.push_pc;
          if ((r.sp[1:0] != IEX_ALIGN_OK) && (r.kind != IEX_K_ADE)) begin
            n.ade_after = 1'b1;
          end
          n.st = IEX_PUSH_PC;
        end
      end
      IEX_PUSH_PC: begin
        if (bus_ack_i) begin
          n.bus.write = 1'b0;
          n.bus.addr = vec_addr;
          n.bus.wdata = '0;
          // Ignored in address error processing to stop a loop
          if ((vector_table_base_i[1:0] != IEX_ALIGN_OK) && (r.kind != IEX_K_ADE)) begin
            n.ade_after = 1'b1;
          end
          n.st = IEX_FETCH_VEC;
        end
      end
      IEX_FETCH_VEC: begin
        if (bus_ack_i) begin
          if (r.ade_after) begin
            // Handler address becomes the return point of the error
            n.kind = IEX_K_ADE;
            n.vec = VEC_ADE;
            n.push_pc = bus_rdata_i;
            n.ade_after = 1'b0;
            n.sp = r.sp - IEX_STACK_STEP;
            n.sp_we = 1'b1;
            n.bus.write = 1'b1;
            n.bus.addr = r.sp - IEX_STACK_STEP;
            n.bus.wdata = status_word_i;
            n.st = IEX_PUSH_SR;
          end else begin
            // Jump straight to the handler, no slot executes
            n.pc = bus_rdata_i;
            n.pc_load = 1'b1;
            n.busy = 1'b0;
            n.bus = '0;
            n.st = IEX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= IEX_CORE_RST;
    end else begin
      r <= n;
    end
  end

  assign dec_go_o = r.go;
  assign busy_o = r.busy;
  assign sp_o = r.sp;
  assign sp_we_o = r.sp_we;
  assign pc_o = r.pc;
  assign pc_load_o = r.pc_load;
  assign irq_ack_o = r.irq_ack;
  assign bus_o = r.bus;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take;
    decide && pk.take;
  endsequence
  sequence s_sr_done;
    r.st == IEX_PUSH_SR && bus_ack_i;
  endsequence
  sequence s_pc_done;
    r.st == IEX_PUSH_PC && bus_ack_i;
  endsequence
  sequence s_vec_done;
    r.st == IEX_FETCH_VEC && bus_ack_i;
  endsequence

  AST_SR_FIRST: assert property (s_take |=> bus_o.req && bus_o.write &&
    bus_o.wdata == $past(status_word_i) &&
    bus_o.addr == $past(stack_pointer_i) - IEX_STACK_STEP)
    else $error("status word not pushed first");
  AST_PC_SECOND: assert property (s_sr_done |=> bus_o.write &&
    bus_o.wdata == r.push_pc && bus_o.addr == $past(bus_o.addr) - IEX_STACK_STEP &&
    sp_o == bus_o.addr && sp_we_o)
    else $error("program counter push wrong");
  AST_TRAP_PC: assert property ((s_take and pk.kind == IEX_K_TRAP) |=>
    r.push_pc == $past(dec_i.next_pc) && r.vec == $past(dec_i.trap_vec))
    else $error("trap return address wrong");
  AST_GEN_PC: assert property ((s_take and pk.kind == IEX_K_GEN) |=>
    r.push_pc == $past(dec_i.pc) && r.vec == VEC_GEN)
    else $error("illegal instruction address wrong");
  AST_SLOT_PC: assert property ((s_take and in_slot && dec_i.undefined) |=>
    r.kind == IEX_K_SLOT && r.push_pc == $past(slot_target))
    else $error("slot exception return address wrong");
  AST_SLOT_TRAP: assert property ((s_take and in_slot && dec_i.trap) |=>
    r.kind == IEX_K_SLOT && r.vec == VEC_SLOT)
    else $error("trap in delay slot not caught");
  AST_VEC_ADDR: assert property (s_pc_done |=> bus_o.req && !bus_o.write &&
    bus_o.addr == $past(vector_table_base_i) + (32'(r.vec) << IEX_VEC_SHIFT))
    else $error("vector address wrong");
  AST_SLOT_HOLD: assert property ((decide && in_slot) |->
    !(pk.take && (pk.kind == IEX_K_IRQ || pk.kind == IEX_K_ADE)))
    else $error("exception inserted after delayed branch");
  AST_CTRL_HOLD: assert property ((decide && after_dis && !in_slot) |->
    (pk.kind != IEX_K_IRQ) && (!ade_pend || pk.kind == IEX_K_ADE))
    else $error("acceptance after control access wrong");
  AST_SP_ERR: assert property ((s_take and stack_pointer_i[1:0] != IEX_ALIGN_OK &&
    pk.kind != IEX_K_ADE) |=> r.ade_after ##1 r.ade_after)
    else $error("stacking address error missed");
  AST_CHAIN_ADE: assert property ((s_vec_done and r.ade_after) |=>
    r.kind == IEX_K_ADE && r.push_pc == $past(bus_rdata_i) && busy_o && !pc_load_o)
    else $error("address error processing not chained");
  AST_ADE_NO_LOOP: assert property ((s_vec_done and r.kind == IEX_K_ADE) |=>
    pc_load_o && pc_o == $past(bus_rdata_i) && !busy_o)
    else $error("address error processing looped");
  AST_NO_DELAY: assert property ((s_vec_done and !r.ade_after) |=>
    pc_load_o && !dec_go_o ##1 !pc_load_o)
    else $error("handler branch not immediate");
endmodule // iex_unit
`default_nettype wire

// ### bench/iex_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module iex_mem_model import iex_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Bus from the unit
  input wire iex_bus_t bus_i,
  input wire logic [1:0] dly_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  int cnt;
  initial begin
    ack_o = 1'b0;
    rdata_o = 32'h0000_0000;
    cnt = 0;
  end
  // Vector entries hold a fixed scramble of their own address
  always @(posedge sys_clk) begin
    #1;
    rdata_o = ~rdata_o; // Stale data is inverted every cycle
    if (ack_o || !bus_i.req) begin
      ack_o = 1'b0;
      cnt = dly_i;
    end else if (cnt == 0) begin
      ack_o = 1'b1; // Misaligned writes accepted as issued
      if (!bus_i.write) rdata_o = bus_i.addr ^ 32'h5A5A_0000;
    end else begin
      cnt = cnt - 1;
    end
  end
endmodule // iex_mem_model
`default_nettype wire

// ### bench/iex_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module iex_unit_tb_top import iex_pkg::*;;
  localparam logic [7:0] VSLOT = 8'h11;
  localparam logic [7:0] VGEN = 8'h10;
  localparam logic [7:0] VADE = 8'h12;
  typedef struct {bit w; logic [31:0] a; logic [31:0] d;} iex_acc_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  iex_dec_t dec_i = '0;
  logic dec_go_o, busy_o, sp_we_o, pc_load_o, irq_ack_o, bus_ack_i;
  logic [31:0] sp_o, pc_o, bus_rdata_i, r, pc, hexp;
  logic [31:0] sr = 32'h0000_00F0;
  logic [31:0] sp = 32'h8000_0100;
  logic [31:0] vector_table_base = 32'h0000_0400;
  logic ade_req_i = 1'b0;
  logic irq_req_i = 1'b0;
  logic [7:0] irq_vec_i = 8'h40;
  logic [1:0] dly = 2'h0;
  logic [4:0] pats [4] = '{5'h10, 5'h04, 5'h06, 5'h0C};
  logic [15:0] lfsr = 16'hD4A1;
  iex_bus_t bus_o;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  iex_acc_t q[$];

  iex_unit #(.VEC_SLOT(VSLOT), .VEC_GEN(VGEN), .VEC_ADE(VADE)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .dec_i(dec_i), .dec_go_o(dec_go_o), .busy_o(busy_o),
    .status_word_i(sr), .stack_pointer_i(sp), .vector_table_base_i(vector_table_base), .sp_o(sp_o),
    .sp_we_o(sp_we_o), .pc_o(pc_o), .pc_load_o(pc_load_o), .ade_req_i(ade_req_i),
    .irq_req_i(irq_req_i), .irq_vec_i(irq_vec_i), .irq_ack_o(irq_ack_o), .bus_o(bus_o),
    .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i));
  iex_mem_model u_mem (.sys_clk(sys_clk), .bus_i(bus_o), .dly_i(dly), .ack_o(bus_ack_i),
    .rdata_o(bus_rdata_i));

  always #12.5 sys_clk = ~sys_clk;

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Longest run is well under a few thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rnd();
    for (int i = 0; i < 32; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      r = {r[30:0], lfsr[0]};
    end
  endtask

  // Flags: undefined, delayed branch, rewrites pc, trap, interrupt disabling
  function automatic iex_dec_t mk(input logic [31:0] a, input logic [4:0] f, input logic [7:0] v);
    mk = '0;
    mk.valid = 1'b1;
    mk.pc = a;
    mk.next_pc = a + 32'h2;
    mk.target = a + 32'h100;
    {mk.undefined, mk.delayed_br, mk.rewrites_pc, mk.trap, mk.int_disable} = f;
    mk.trap_vec = v;
  endfunction

  task automatic decode(input iex_dec_t d, input logic exc, input logic ia);
    @(posedge sys_clk);
    #1 dec_i = d;
    @(posedge sys_clk);
    #1 dec_i.valid = 1'b0;
    chk({31'h0, busy_o}, {31'h0, exc});
    chk({31'h0, dec_go_o}, {31'h0, !exc});
    chk({31'h0, irq_ack_o}, {31'h0, ia});
  endtask

  task automatic pulse_ade();
    ade_req_i = 1'b1;
    @(posedge sys_clk);
    #1 ade_req_i = 1'b0;
  endtask

  // Reference sequence: status word, pc, vector read, then on misalignment a chained address error
  task automatic run(input logic [31:0] pp, input logic [7:0] v, input logic ade);
    iex_acc_t e;
    q = {};
    q.push_back('{1'b1, sp - 32'h4, sr});
    q.push_back('{1'b1, sp - 32'h8, pp});
    q.push_back('{1'b0, vector_table_base + {22'h0, v, 2'h0}, 32'h0});
    hexp = (vector_table_base + {22'h0, v, 2'h0}) ^ 32'h5A5A_0000;
    if (!ade && (sp[1:0] != 2'h0 || vector_table_base[1:0] != 2'h0)) begin
      q.push_back('{1'b1, sp - 32'hC, sr});
      q.push_back('{1'b1, sp - 32'h10, hexp});
      q.push_back('{1'b0, vector_table_base + {22'h0, VADE, 2'h0}, 32'h0});
      hexp = (vector_table_base + {22'h0, VADE, 2'h0}) ^ 32'h5A5A_0000;
    end
    // Look mid-cycle so registered outputs and the ack are both settled
    for (int i = 0; i < 300 && !pc_load_o; i++) begin
      @(negedge sys_clk);
      if (bus_o.req && bus_ack_i) begin
        e = q.pop_front();
        chk({31'h0, bus_o.write}, {31'h0, e.w});
        chk(bus_o.addr, e.a);
        if (e.w && e.a[1:0] == 2'h0) chk(bus_o.wdata, e.d);
        if (e.w) chk(sp_o, e.a);
      end
      if (pc_load_o) chk(pc_o, hexp);
    end
    @(posedge sys_clk);
    #1;
    chk(32'(q.size()), 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // Traps over random vectors and memory speeds
    for (int i = 0; i < 6; i++) begin
      rnd();
      dly = r[1:0];
      pc = {16'h0000, r[15:1], 1'b0};
      sp = {16'h8000, r[31:18], 2'h0};
      decode(mk(pc, 5'h06, r[23:16]), 1'b1, 1'b0);
      run(pc + 32'h2, r[23:16], 1'b0);
    end
    decode(mk(pc, 5'h10, 8'h00), 1'b1, 1'b0);
    run(pc, VGEN, 1'b0);
    // Every kind of illegal slot content
    for (int i = 0; i < 4; i++) begin
      decode(mk(pc, 5'h0C, 8'h00), 1'b0, 1'b0);
      decode(mk(pc + 32'h2, pats[i], 8'h21), 1'b1, 1'b0);
      run(pc + 32'h100, VSLOT, 1'b0);
    end
    // Slot holds both error and interrupt; error wins afterwards
    rnd();
    irq_vec_i = r[7:0];
    decode(mk(pc, 5'h0C, 8'h00), 1'b0, 1'b0);
    irq_req_i = 1'b1;
    pulse_ade();
    decode(mk(pc + 32'h2, 5'h00, 8'h00), 1'b0, 1'b0);
    decode(mk(pc + 32'h100, 5'h00, 8'h00), 1'b1, 1'b0);
    run(pc + 32'h100, VADE, 1'b1);
    decode(mk(pc, 5'h00, 8'h00), 1'b1, 1'b1);
    irq_req_i = 1'b0;
    run(pc, irq_vec_i, 1'b0);
    // Interrupt-disabling op holds interrupts only
    decode(mk(pc, 5'h01, 8'h00), 1'b0, 1'b0);
    irq_req_i = 1'b1;
    decode(mk(pc + 32'h2, 5'h00, 8'h00), 1'b0, 1'b0);
    decode(mk(pc + 32'h4, 5'h00, 8'h00), 1'b1, 1'b1);
    irq_req_i = 1'b0;
    run(pc + 32'h4, irq_vec_i, 1'b0);
    decode(mk(pc, 5'h01, 8'h00), 1'b0, 1'b0);
    pulse_ade();
    decode(mk(pc + 32'h2, 5'h00, 8'h00), 1'b1, 1'b0);
    run(pc + 32'h2, VADE, 1'b1);
    // Misaligned stack, then misaligned vector base
    sp = 32'h8000_0102;
    decode(mk(pc, 5'h06, 8'h33), 1'b1, 1'b0);
    run(pc + 32'h2, 8'h33, 1'b0);
    pulse_ade();
    decode(mk(pc, 5'h00, 8'h00), 1'b1, 1'b0);
    run(pc, VADE, 1'b1);
    sp = 32'h8000_0100;
    vector_table_base = 32'h0000_0402;
    decode(mk(pc, 5'h10, 8'h00), 1'b1, 1'b0);
    run(pc, VGEN, 1'b0);
    final_report();
  end
endmodule // iex_unit_tb_top
`default_nettype wire
